// ==== logic/nvsc_ctrl.sv ====
// host-side controller that drives an nvsram through its asynchronous pins
// How it works
// - address is set before the write and held until both lines rise.
// - output enable stays high for every write; device floats its drivers.
// - software store issues the six reads ending at 0fc0, in order.
// - software recall issues the same five reads, then 0c63.
// - each sequence step has its own chip select pulse.
// - sequence steps are reads with output enable held high.
// - write enable and select are held high through power-up recall.
`timescale 1ns/10ps
`include "nvsc_defines.svh"

module nvsc_ctrl
    import nvsc_pkg::*;
#(
    parameter int TW = `NVSC_TW,
    parameter int STORE_CYC = `NVSC_CYC_MS(`NVSC_STORE_MS),
    parameter int RESTORE_CYC = `NVSC_CYC_US(`NVSC_RESTORE_US),
    parameter int RECALL_CYC = `NVSC_CYC_US(`NVSC_RECALL_US)
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // supply indicators
    input wire logic below_trigger_level,
    input wire logic below_reset_level,
    // user request
    input wire logic req_valid,
    input wire nvsc_req_t req,
    output logic req_ready,
    // user response
    output logic rsp_valid,
    output nvsc_rsp_t rsp,
    // memory pins
    output nvsc_pins_t pins,
    input wire logic [`NVSC_DW-1:0] dq_in
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    localparam int RD_CYC = `NVSC_CYC_NS(`NVSC_ACCESS_NS);
    localparam int WR_CYC = `NVSC_CYC_NS(`NVSC_WR_PULSE_NS);
    localparam int SQ_CYC = `NVSC_CYC_NS(`NVSC_SEQ_PULSE_NS);

    if (TW < 2 || STORE_CYC < 1 || RESTORE_CYC < 1 || RECALL_CYC < 1) begin : g_bad_count
        $error("nvsc_ctrl: counts must be at least one and TW at least two");
    end
    if (STORE_CYC >= 2 ** TW || RESTORE_CYC >= 2 ** TW || RECALL_CYC >= 2 ** TW) begin : g_wide
        $error("nvsc_ctrl: a duration does not fit the timer width");
    end

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // top address bit is driven low on every step
    function automatic logic [`NVSC_AW-1:0] seq_addr(input logic [2:0] step,
                                                    input logic recall);
        case (step)
            3'h0: seq_addr = `NVSC_SEQ_A0;
            3'h1: seq_addr = `NVSC_SEQ_A1;
            3'h2: seq_addr = `NVSC_SEQ_A2;
            3'h3: seq_addr = `NVSC_SEQ_A3;
            3'h4: seq_addr = `NVSC_SEQ_A4;
            default: seq_addr = recall ? `NVSC_SEQ_RECALL : `NVSC_SEQ_STORE;
        endcase
    endfunction : seq_addr

    function automatic logic [TW-1:0] to_tw(input int n);
        to_tw = n[TW-1:0];
    endfunction : to_tw

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    nvsc_state_t state;
    nvsc_cmd_t cmd;
    logic [`NVSC_DW-1:0] wdata;
    logic [2:0] step;
    logic armed;
    wire logic timer_done;

    wire logic low_supply = below_trigger_level || below_reset_level;
    wire logic is_sw = (cmd == NVSC_CMD_STORE) || (cmd == NVSC_CMD_RECALL);
    wire logic is_write = (cmd == NVSC_CMD_WRITE);
    wire logic take = (state == NVSC_ST_IDLE) && req_valid && req_ready && !low_supply;
    wire logic seq_more = is_sw && (step != `NVSC_SEQ_LAST);
    wire logic seq_done = is_sw && (step == `NVSC_SEQ_LAST);
    // a drop in supply cuts any access short so that no write is left open
    wire logic abort = low_supply && (state != NVSC_ST_POWER) && (state != NVSC_ST_IDLE);
    wire logic go_power = low_supply && (state != NVSC_ST_POWER);

    wire logic [TW-1:0] pulse_val = is_write ? to_tw(WR_CYC - 1) :
                                    (is_sw ? to_tw(SQ_CYC - 1) : to_tw(RD_CYC - 1));
    wire logic [TW-1:0] nv_val = (cmd == NVSC_CMD_RECALL) ? to_tw(RECALL_CYC - 1)
                                                          : to_tw(STORE_CYC - 1);
    wire logic power_load = (state == NVSC_ST_POWER) && (low_supply || !armed);
    wire logic timer_load = power_load || (state == NVSC_ST_SETUP) ||
                            ((state == NVSC_ST_END) && seq_done);
    wire logic [TW-1:0] timer_val = (state == NVSC_ST_POWER) ? to_tw(RESTORE_CYC - 1) :
                                    ((state == NVSC_ST_SETUP) ? pulse_val : nv_val);

    nvsc_timer #(
        .TW(TW)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .load(timer_load),
        .load_val(timer_val),
        .done(timer_done)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    nvsc_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            NVSC_ST_POWER: begin
                if (!power_load && timer_done) begin
                    next_state = NVSC_ST_IDLE;
                end
            end
            NVSC_ST_IDLE: begin
                if (take) begin
                    next_state = NVSC_ST_SETUP;
                end
            end
            NVSC_ST_SETUP: next_state = NVSC_ST_PULSE;
            NVSC_ST_PULSE: begin
                if (timer_done) begin
                    next_state = NVSC_ST_END;
                end
            end
            NVSC_ST_END: begin
                if (seq_more) begin
                    next_state = NVSC_ST_SETUP;
                end else if (seq_done) begin
                    next_state = NVSC_ST_WAIT;
                end else begin
                    next_state = NVSC_ST_IDLE;
                end
            end
            NVSC_ST_WAIT: begin
                if (timer_done) begin
                    next_state = NVSC_ST_IDLE;
                end
            end
            default: next_state = NVSC_ST_POWER;
        endcase
        if (go_power) begin
            next_state = NVSC_ST_POWER;
        end
    end

    // ------------------------------------------------------------------------
    // sequencing registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= NVSC_ST_POWER;
            cmd <= NVSC_CMD_READ;
            wdata <= '0;
            step <= `NVSC_STEP_ZERO;
            armed <= 1'b0;
        end else begin
            state <= next_state;
            armed <= 1'b1;
            if (take) begin
                cmd <= req.cmd;
                wdata <= req.wdata;
                step <= `NVSC_STEP_ZERO;
            end else if (state == NVSC_ST_END && seq_more) begin
                step <= step + `NVSC_STEP_ONE;
            end
        end
    end

    // ------------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------------
    // pins park with select, write and output enable high and drivers off
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
        end else if (go_power) begin
            pins.ce_n <= 1'b1;
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.dq_oe <= 1'b0;
        end else begin
            case (state)
                NVSC_ST_IDLE: begin
                    if (take) begin
                        pins.addr <= (req.cmd == NVSC_CMD_STORE || req.cmd == NVSC_CMD_RECALL) ?
                                     seq_addr(`NVSC_STEP_ZERO, req.cmd == NVSC_CMD_RECALL) :
                                     req.addr;
                    end
                end
                NVSC_ST_SETUP: begin
                    pins.ce_n <= 1'b0;
                    pins.we_n <= !is_write;
                    pins.oe_n <= is_write || is_sw;
                    pins.dq_oe <= is_write;
                    pins.dq_out <= wdata;
                end
                NVSC_ST_PULSE: begin
                    if (timer_done) begin
                        pins.ce_n <= 1'b1;
                        pins.we_n <= 1'b1;
                        pins.oe_n <= 1'b1;
                    end
                end
                NVSC_ST_END: begin
                    pins.dq_oe <= 1'b0;
                    if (seq_more) begin
                        pins.addr <= seq_addr(step + `NVSC_STEP_ONE, cmd == NVSC_CMD_RECALL);
                    end
                end
                default: begin
                    pins.ce_n <= 1'b1;
                    pins.we_n <= 1'b1;
                    pins.oe_n <= 1'b1;
                    pins.dq_oe <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // user side
    // ------------------------------------------------------------------------
    wire logic finish = ((state == NVSC_ST_END) && !seq_more && !seq_done) ||
                        ((state == NVSC_ST_WAIT) && timer_done);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= (finish && !low_supply) || abort;
            if (abort) begin
                rsp.err <= 1'b1;
            end else if (finish) begin
                rsp.err <= 1'b0;
            end
            if (state == NVSC_ST_PULSE && timer_done && cmd == NVSC_CMD_READ) begin
                rsp.rdata <= dq_in;
            end
            req_ready <= (next_state == NVSC_ST_IDLE) && !low_supply;
        end
    end

endmodule : nvsc_ctrl

// ==== logic/nvsc_defines.svh ====
// timing figures, sequence addresses and widths for the nvsram host controller
`ifndef NVSC_DEFINES_SVH
`define NVSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define NVSC_AW 15
`define NVSC_DW 8
`define NVSC_TW 20

// ----------------------------------------------------------------------------
// timing, in the units printed, plus the system clock period
// ----------------------------------------------------------------------------
`define NVSC_CLK_NS 20
`define NVSC_ACCESS_NS 45
`define NVSC_WR_PULSE_NS 30
`define NVSC_SEQ_PULSE_NS 30
`define NVSC_RECALL_US 20
`define NVSC_STORE_MS 10
`define NVSC_RESTORE_US 550

// least times round up to whole clock cycles
`define NVSC_CYC_NS(t) (((t) + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CYC_US(t) `NVSC_CYC_NS((t) * 1000)
`define NVSC_CYC_MS(t) `NVSC_CYC_NS((t) * 1000000)

// ----------------------------------------------------------------------------
// software store / recall sequence
// ----------------------------------------------------------------------------
`define NVSC_SEQ_A0 15'h0e38
`define NVSC_SEQ_A1 15'h31c7
`define NVSC_SEQ_A2 15'h03e0
`define NVSC_SEQ_A3 15'h3c1f
`define NVSC_SEQ_A4 15'h303f
`define NVSC_SEQ_STORE 15'h0fc0
`define NVSC_SEQ_RECALL 15'h0c63
`define NVSC_SEQ_LAST 3'h5
`define NVSC_STEP_ZERO 3'h0
`define NVSC_STEP_ONE 3'h1

`endif

// ==== logic/nvsc_pkg.sv ====
// types shared by the nvsram host controller
`include "nvsc_defines.svh"

package nvsc_pkg;

    // ------------------------------------------------------------------------
    // commands and states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        NVSC_CMD_READ = 2'h0,
        NVSC_CMD_WRITE = 2'h1,
        NVSC_CMD_STORE = 2'h2,
        NVSC_CMD_RECALL = 2'h3
    } nvsc_cmd_t;

    typedef enum logic [5:0] {
        NVSC_ST_POWER = 6'h01,
        NVSC_ST_IDLE = 6'h02,
        NVSC_ST_SETUP = 6'h04,
        NVSC_ST_PULSE = 6'h08,
        NVSC_ST_END = 6'h10,
        NVSC_ST_WAIT = 6'h20
    } nvsc_state_t;

    // ------------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        nvsc_cmd_t cmd;
        logic [`NVSC_AW-1:0] addr;
        logic [`NVSC_DW-1:0] wdata;
    } nvsc_req_t;

    typedef struct packed {
        logic [`NVSC_DW-1:0] rdata;
        logic err;
    } nvsc_rsp_t;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [`NVSC_AW-1:0] addr;
        logic [`NVSC_DW-1:0] dq_out;
        logic dq_oe;
    } nvsc_pins_t;

endpackage : nvsc_pkg

// ==== logic/nvsc_timer.sv ====
// down-counter that times pin phases and nonvolatile waits
`timescale 1ns/10ps
`include "nvsc_defines.svh"

module nvsc_timer #(
    parameter int TW = `NVSC_TW
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic load,
    input wire logic [TW-1:0] load_val,
    // status
    output logic done
);

    logic [TW-1:0] count;
    wire logic [TW-1:0] next_count;

    assign next_count = load ? load_val : ((count != '0) ? count - 1'b1 : count);
    assign done = (count == '0) && !load;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

endmodule : nvsc_timer

// ==== verif/nvsc_ctrl_sva.sv ====
// port checks for the nvsram host controller
`timescale 1ns/10ps
`include "nvsc_defines.svh"
module nvsc_ctrl_sva
    import nvsc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // supply and user side
    input wire logic below_trigger_level,
    input wire logic below_reset_level,
    input wire logic req_valid,
    input wire nvsc_req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire nvsc_rsp_t rsp,
    // memory pins
    input wire nvsc_pins_t pins,
    input wire logic [`NVSC_DW-1:0] dq_in
);
    // ------------------------------------------------------------------------
    // pin and handshake relations
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire low = below_trigger_level || below_reset_level;
    wire take = req_valid && req_ready && !low;
    wire parked = pins.ce_n && pins.we_n && pins.oe_n && !pins.dq_oe;
    property p_rst_park;
        disable iff (1'h0) rst |=> parked;
    endproperty
    a_rst_park: assert property (p_rst_park) else $error("pins active after reset");
    property p_low_refuse;
        low ##1 low |-> !req_ready;
    endproperty
    a_low_refuse: assert property (p_low_refuse) else $error("ready at low supply");
    property p_low_park;
        low |=> parked;
    endproperty
    a_low_park: assert property (p_low_park) else $error("pins not parked");
    property p_rd_lat;
        take && req.cmd == NVSC_CMD_READ |-> ##[6:7] rsp_valid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_rd_pulse;
        $fell(pins.oe_n) |-> (!pins.oe_n && !pins.ce_n && pins.we_n)[*3] ##1 pins.ce_n;
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("bad read pulse");
    property p_wr_pulse;
        $fell(pins.we_n) |-> (!pins.we_n && !pins.ce_n && pins.oe_n)[*2]
            ##1 (pins.we_n && pins.ce_n && pins.dq_oe && $stable(pins.dq_out));
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("bad write pulse");
    property p_addr_hold;
        $past(!pins.ce_n) |-> $stable(pins.addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved");
    property p_seq_step;
        !pins.ce_n && pins.oe_n && pins.we_n |-> !pins.addr[14] && !pins.dq_oe;
    endproperty
    a_seq_step: assert property (p_seq_step) else $error("bad sequence step");
    property p_oe_write;
        pins.dq_oe |-> pins.oe_n;
    endproperty
    a_oe_write: assert property (p_oe_write) else $error("bus contention");
    c_read: cover property (take && req.cmd == NVSC_CMD_READ);
    c_store: cover property (take && req.cmd == NVSC_CMD_STORE);
    c_abort: cover property (rsp_valid && rsp.err);
endmodule : nvsc_ctrl_sva

bind nvsc_ctrl nvsc_ctrl_sva i_sva (
    .sys_clk(sys_clk), .rst(rst),
    .below_trigger_level(below_trigger_level), .below_reset_level(below_reset_level),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in)
);

// ==== verif/nvsc_mem_model.sv ====
// behavioural nvsram answering the host controller's pins
`timescale 1ns/10ps
`include "nvsc_defines.svh"
module nvsc_mem_model
    import nvsc_pkg::*;
#(
    parameter int STORE_NS = 300,
    parameter int RECALL_NS = 150,
    parameter int RESTORE_NS = 500
) (
    // host pins and supply indicators
    input wire nvsc_pins_t pins,
    input wire logic below_trigger_level,
    input wire logic below_reset_level,
    // bus as the host sees it
    output logic [`NVSC_DW-1:0] dq_in
);
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [13:0] seq [0:4] = '{14'h0e38, 14'h31c7, 14'h03e0, 14'h3c1f, 14'h303f};
    logic [7:0] last = 8'h00;
    logic busy = 1'h0;
    logic dirty = 1'h0;
    logic pend = 1'h0;
    int step = 0;
    wire rd_en = !pins.ce_n && !pins.oe_n && pins.we_n && !busy;
    wire wr_on = !pins.ce_n && !pins.we_n;
    // released bus shows the inverse of the last read, zero only after a read of ff
    assign dq_in = pins.dq_oe ? pins.dq_out : (rd_en ? mem[pins.addr] : ~last);
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
            nv[i] = 8'h00;
        end
    end
    always @(negedge rd_en) last = mem[pins.addr];
    task automatic run(input logic st);
        busy = 1'h1;
        step = 0;
        if (st)
            nv = mem;
        else
            mem = nv;
        dirty = 1'h0;
        #(st ? STORE_NS : RECALL_NS);
        busy = 1'h0;
    endtask : run
    // only a write that really opened may land; the unknown-to-parked step at reset must not
    logic wr_open = 1'h0;
    always @(posedge wr_on) wr_open = 1'h1;
    always @(negedge wr_on) begin
        if (wr_open && !busy && !below_trigger_level) begin
            mem[pins.addr] = dq_in;
            dirty = 1'h1;
        end
        wr_open = 1'h0;
    end
    // steps are judged at the select edge; let simultaneous pin changes land
    always @(negedge pins.ce_n) begin
        #1;
        if (!busy) begin
            if (!pins.we_n)
                step = 0;
            else if (step == 5 && pins.addr[13:0] == 14'h0fc0 && !below_trigger_level)
                run(1'h1);
            else if (step == 5 && pins.addr[13:0] == 14'h0c63)
                run(1'h0);
            else if (step < 5 && pins.addr[13:0] == seq[step])
                step++;
            else
                step = int'(pins.addr[13:0] == seq[0]);
        end
    end
    always @(posedge below_trigger_level) begin
        if (dirty) begin
            nv = mem;
            dirty = 1'h0;
        end
    end
    always @(posedge below_reset_level) pend = 1'h1;
    always @(negedge below_trigger_level) begin
        if (pend) begin
            pend = 1'h0;
            busy = 1'h1;
            step = 0;
            mem = nv;
            #(RESTORE_NS);
            busy = 1'h0;
        end
    end
endmodule : nvsc_mem_model

// ==== verif/test_nvsc_ctrl.sv ====
// self-checking bench for the nvsram host controller
`timescale 1ns/10ps
module test_nvsc_ctrl;
    import nvsc_pkg::*;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic below_trigger_level = 1'h0;
    logic below_reset_level = 1'h0;
    logic req_valid = 1'h0;
    nvsc_req_t req = '0;
    logic req_ready;
    logic rsp_valid;
    nvsc_rsp_t rsp;
    nvsc_pins_t pins;
    logic [7:0] dq_in;
    int fails = 0;
    int checks = 0;
    logic [7:0] ref_mem [0:32767];
    logic [7:0] ref_nv [0:32767];
    logic ref_dirty = 1'h0;
    logic [14:0] aq [$];
    logic [14:0] a = 15'h4123;

    always #10 sys_clk = ~sys_clk;

    // short nonvolatile waits keep the run brief
    nvsc_ctrl #(.STORE_CYC(20), .RESTORE_CYC(30), .RECALL_CYC(10)) i_dut (
        .sys_clk(sys_clk), .rst(rst),
        .below_trigger_level(below_trigger_level), .below_reset_level(below_reset_level),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .dq_in(dq_in)
    );
    nvsc_mem_model i_mem (
        .pins(pins), .below_trigger_level(below_trigger_level),
        .below_reset_level(below_reset_level), .dq_in(dq_in)
    );

    // ------------------------------------------------------------------------
    // bus tasks and the reference memory
    // ------------------------------------------------------------------------
    task automatic summarize;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_for(input int which);
        int n;
        n = 0;
        while ((which ? rsp_valid : req_ready) !== 1'h1 && n < 2000) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if ((which ? rsp_valid : req_ready) !== 1'h1) begin
            fails++;
            summarize();
        end
    endtask : wait_for
    task automatic do_op(input nvsc_cmd_t c, input logic [14:0] ad, input logic [7:0] wd,
                         input logic err);
        wait_for(0);
        req = '{cmd: c, addr: ad, wdata: wd};
        req_valid = 1'h1;
        @(posedge sys_clk);
        #1;
        req_valid = 1'h0;
        wait_for(1);
        check(rsp.err, err);
        if (!err) begin
            case (c)
                NVSC_CMD_READ: check(rsp.rdata, ref_mem[ad]);
                NVSC_CMD_WRITE: begin
                    ref_mem[ad] = wd;
                    ref_dirty = 1'h1;
                end
                NVSC_CMD_STORE: ref_nv = ref_mem;
                default: ref_mem = ref_nv;
            endcase
            if (c[1])
                ref_dirty = 1'h0;
        end
    endtask : do_op

    initial begin
        void'($urandom(35301));
        foreach (ref_mem[i]) begin
            ref_mem[i] = 8'h00;
            ref_nv[i] = 8'h00;
        end
        repeat (3) @(posedge sys_clk);
        #1;
        rst = 1'h0;
        check(pins.ce_n & pins.we_n & pins.oe_n, 8'h01);
        repeat (20) @(posedge sys_clk);
        #1;
        check(req_ready, 8'h00);
        aq = '{15'h0000, 15'h7fff};
        repeat (6) aq.push_back(15'($urandom));
        foreach (aq[i]) do_op(NVSC_CMD_WRITE, aq[i], 8'($urandom), 1'h0);
        foreach (aq[i]) do_op(NVSC_CMD_READ, aq[i], 8'h00, 1'h0);
        // a write offered at low supply must never be taken
        below_trigger_level = 1'h1;
        if (ref_dirty)
            ref_nv = ref_mem;
        ref_dirty = 1'h0;
        req = '{cmd: NVSC_CMD_WRITE, addr: aq[0], wdata: 8'hee};
        req_valid = 1'h1;
        repeat (10) @(posedge sys_clk);
        #1;
        check(req_ready, 8'h00);
        below_trigger_level = 1'h0;
        req_valid = 1'h0;
        do_op(NVSC_CMD_READ, aq[0], 8'h00, 1'h0);
        do_op(NVSC_CMD_WRITE, a, 8'h5a, 1'h0);
        do_op(NVSC_CMD_STORE, 15'h7fff, 8'h00, 1'h0);
        do_op(NVSC_CMD_WRITE, a, 8'ha5, 1'h0);
        repeat (2) begin
            do_op(NVSC_CMD_RECALL, 15'h7fff, 8'h00, 1'h0);
            do_op(NVSC_CMD_READ, a, 8'h00, 1'h0);
        end
        // supply dip in the middle of a software store
        do_op(NVSC_CMD_WRITE, a, 8'h3c, 1'h0);
        fork
            do_op(NVSC_CMD_STORE, 15'h0000, 8'h00, 1'h1);
            begin
                repeat (10) @(posedge sys_clk);
                #1;
                below_trigger_level = 1'h1;
                below_reset_level = 1'h1;
            end
        join
        ref_nv = ref_mem;
        ref_dirty = 1'h0;
        repeat (5) @(posedge sys_clk);
        #1;
        below_reset_level = 1'h0;
        below_trigger_level = 1'h0;
        do_op(NVSC_CMD_READ, a, 8'h00, 1'h0);
        do_op(NVSC_CMD_READ, aq[1], 8'h00, 1'h0);
        summarize();
    end
endmodule : test_nvsc_ctrl
